// *** rtl/eeprom_target.sv ***
// Serial memory target front end: conditions, select, write sequence, program cycle
//
// How it works
// RQ1 - Data bits captured on serial clock rise
// RQ2 - Master changes data only while clock low
// RQ3 - Start: data falls while clock high
// RQ4 - Master starts every instruction; target never starts
// RQ5 - Start watch runs except during program cycle
// RQ6 - Stop: data rises while clock high, ends exchange
// RQ7 - Unacknowledged read then Stop returns to Standby
// RQ8 - Receiver pulls data low on ninth pulse
// RQ9 - Select byte: type, chip field, direction
// RQ10 - Direction bit one reads, zero writes
// RQ11 - Matching upper seven bits get acknowledged
// RQ12 - Mismatch: no acknowledge, Standby until Start
// RQ13 - Write: two acknowledged address bytes, then data
// RQ14 - High address byte first, each MSB first
// RQ15 - Program only on Stop in tenth slot
// RQ16 - Afterwards counter points past last written byte
// RQ17 - Program cycle: data output off, requests ignored
// RQ18 - Data output only pulls low or releases
// RQ19 - Supply-up reset release enters Standby
// RQ20 - Reset asserted again stops all responses
// RQ21 - Program length is configurable, busy throughout
// RQ22 - Address counter spans array, loaded from address
`timescale 1ns/1ns
module eeprom_target import eeprom_pkg::*; #(
  parameter int PROG_LEN = PROG_CYCLES,
  parameter int ADDR_W = ARRAY_ADDR_W,
  parameter logic [3:0] TYPE_ID = DEV_TYPE_ID
) (
  // System clock and supply-up reset
  input wire logic clk,
  input wire logic rstn,
  // Serial link
  i2c_link_if.device link,
  // Program cycle side
  output logic progStart,
  output logic [ADDR_W-1:0] progAddr,
  output logic [7:0] progData,
  output logic [DATA_CNT_W-1:0] progBytes,
  output logic busy,
  output logic [ADDR_W-1:0] addrCount
);

  localparam int CNT_W = $clog2(PROG_LEN + 1);

  // Parameter checks
  if (ADDR_W < 1 || ADDR_W > FULL_ADDR_W) begin : gAddrCheck
    $error("ADDR_W out of range");
  end
  if (PROG_LEN < 1) begin : gLenCheck
    $error("PROG_LEN must be at least one");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic linkEn_reg, linkEn_next;
  logic linkRstN;
  logic [7:0] shift_reg, shift_next;
  logic [3:0] bitCnt_reg, bitCnt_next;
  lnk_e state_reg, state_next;
  logic ackWant_reg, ackWant_next;
  logic [7:0] addrHi_reg, addrHi_next;
  logic [7:0] addrLo_reg, addrLo_next;
  logic [7:0] data_reg, data_next;
  logic [DATA_CNT_W-1:0] dataCnt_reg, dataCnt_next;
  logic dataDone_reg, dataDone_next;
  logic armed_reg, armed_next;
  logic ackOe_reg, ackOe_next;
  logic [7:0] rxByte;
  logic [2:0] sclSync_reg, sclSync_next;
  logic [2:0] sdaSync_reg, sdaSync_next;
  logic startDet, stopDet;
  logic startDly_reg, startDly_next;
  logic busy_reg, busy_next;
  logic [CNT_W-1:0] progCnt_reg, progCnt_next;
  logic progStart_reg, progStart_next;
  logic [ADDR_W-1:0] progAddr_reg, progAddr_next;
  logic [7:0] progData_reg, progData_next;
  logic [DATA_CNT_W-1:0] progBytes_reg, progBytes_next;
  logic [ADDR_W-1:0] addrCount_reg, addrCount_next;
  logic [FULL_ADDR_W-1:0] rxAddr;

  ////////////////////////////////////////////////////////////////////////////
  // Link domain, held in reset outside a frame and while programming
  assign linkRstN = rstn & linkEn_reg; // RQ20

  // Byte engine on the serial clock rise
  always_comb begin
    rxByte = {shift_reg[6:0], link.sdaLevel}; // RQ1
    shift_next = rxByte;
    bitCnt_next = (bitCnt_reg == BIT_ACK) ? 4'h0 : bitCnt_reg + 4'h1;
    state_next = state_reg;
    ackWant_next = ackWant_reg;
    addrHi_next = addrHi_reg;
    addrLo_next = addrLo_reg;
    data_next = data_reg;
    dataCnt_next = dataCnt_reg;
    dataDone_next = (bitCnt_reg == BIT_ACK) && (state_reg == LNK_DATA) && ackWant_reg;
    armed_next = dataDone_reg && (bitCnt_reg == 4'h0); // RQ15
    if (bitCnt_reg == BIT_LAST_DATA) begin
      unique case (state_reg)
        LNK_SEL: begin
          if (rxByte[7:1] == {TYPE_ID, CHIP_FIELD}) begin // RQ9
            ackWant_next = 1'b1; // RQ11
            state_next = (rxByte[0] == RW_WRITE) ? LNK_ADDR_HI : LNK_PARK; // RQ10
          end else begin
            ackWant_next = 1'b0; // RQ12
            state_next = LNK_PARK; // RQ12
          end
        end
        LNK_ADDR_HI: begin
          addrHi_next = rxByte; // RQ14
          ackWant_next = 1'b1; // RQ13
          state_next = LNK_ADDR_LO;
        end
        LNK_ADDR_LO: begin
          addrLo_next = rxByte; // RQ14
          ackWant_next = 1'b1; // RQ13
          state_next = LNK_DATA;
        end
        LNK_DATA: begin
          data_next = rxByte;
          dataCnt_next = dataCnt_reg + 1'b1;
          ackWant_next = 1'b1; // RQ8
        end
        LNK_PARK: begin
          ackWant_next = 1'b0; // RQ7
        end
      endcase
    end
  end

  // Byte engine registers
  always_ff @(posedge link.scl or negedge linkRstN) begin
    if (!linkRstN) begin
      shift_reg <= 8'h00;
      bitCnt_reg <= 4'h0;
      state_reg <= LNK_SEL;
      ackWant_reg <= 1'b0;
      addrHi_reg <= 8'h00;
      addrLo_reg <= 8'h00;
      data_reg <= 8'h00;
      dataCnt_reg <= '0;
      dataDone_reg <= 1'b0;
      armed_reg <= 1'b0;
    end else begin
      shift_reg <= shift_next;
      bitCnt_reg <= bitCnt_next;
      state_reg <= state_next;
      ackWant_reg <= ackWant_next;
      addrHi_reg <= addrHi_next;
      addrLo_reg <= addrLo_next;
      data_reg <= data_next;
      dataCnt_reg <= dataCnt_next;
      dataDone_reg <= dataDone_next;
      armed_reg <= armed_next;
    end
  end

  // Acknowledge driver changes on the clock fall, over the whole ninth pulse
  always_comb begin
    ackOe_next = (bitCnt_reg == BIT_ACK) && ackWant_reg; // RQ8
  end

  always_ff @(negedge link.scl or negedge linkRstN) begin
    if (!linkRstN) begin
      ackOe_reg <= 1'b0;
    end else begin
      ackOe_reg <= ackOe_next;
    end
  end

  // Open-drain data output: pull low or release only
  assign link.devSdaOut = 1'b0; // RQ18
  assign link.devSdaOe = ackOe_reg & ~busy_reg; // RQ17

  ////////////////////////////////////////////////////////////////////////////
  // System domain: pin synchronisers and condition detection
  always_comb begin
    sclSync_next = {sclSync_reg[1:0], link.scl};
    sdaSync_next = {sdaSync_reg[1:0], link.sdaLevel};
    startDet = sclSync_reg[1] & sclSync_reg[2] & sdaSync_reg[2] & ~sdaSync_reg[1]; // RQ3
    stopDet = sclSync_reg[1] & sclSync_reg[2] & ~sdaSync_reg[2] & sdaSync_reg[1]; // RQ6
  end

  // Frame control and program cycle; link words are stable once the clock stands
  always_comb begin
    rxAddr = {addrHi_reg, addrLo_reg};
    startDly_next = startDet & ~busy_reg; // RQ5
    busy_next = busy_reg;
    progCnt_next = progCnt_reg;
    progStart_next = 1'b0;
    progAddr_next = progAddr_reg;
    progData_next = progData_reg;
    progBytes_next = progBytes_reg;
    addrCount_next = addrCount_reg;
    if (busy_reg) begin
      if (progCnt_reg == CNT_W'(PROG_LEN - 1)) begin // RQ21
        busy_next = 1'b0;
        addrCount_next = progAddr_reg + ADDR_W'(progBytes_reg); // RQ16
      end else begin
        progCnt_next = progCnt_reg + 1'b1;
      end
    end else if (stopDet && linkEn_reg && armed_reg) begin // RQ15
      busy_next = 1'b1; // RQ21
      progCnt_next = '0;
      progStart_next = 1'b1;
      progAddr_next = rxAddr[ADDR_W-1:0]; // RQ22
      progData_next = data_reg;
      progBytes_next = dataCnt_reg;
    end
    // Start re-arms the link, Stop and programming park it in Standby
    if (busy_next || stopDet || startDet) begin
      linkEn_next = 1'b0; // RQ17
    end else if (startDly_reg) begin
      linkEn_next = 1'b1; // RQ3
    end else begin
      linkEn_next = linkEn_reg;
    end
  end

  // System domain registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sclSync_reg <= 3'h7;
      sdaSync_reg <= 3'h7;
      linkEn_reg <= 1'b0; // RQ19
      startDly_reg <= 1'b0;
      busy_reg <= 1'b0;
      progCnt_reg <= '0;
      progStart_reg <= 1'b0;
      progAddr_reg <= '0;
      progData_reg <= 8'h00;
      progBytes_reg <= '0;
      addrCount_reg <= '0;
    end else begin
      sclSync_reg <= sclSync_next;
      sdaSync_reg <= sdaSync_next;
      linkEn_reg <= linkEn_next;
      startDly_reg <= startDly_next;
      busy_reg <= busy_next;
      progCnt_reg <= progCnt_next;
      progStart_reg <= progStart_next;
      progAddr_reg <= progAddr_next;
      progData_reg <= progData_next;
      progBytes_reg <= progBytes_next;
      addrCount_reg <= addrCount_next;
    end
  end

  // Outputs
  assign progStart = progStart_reg;
  assign progAddr = progAddr_reg;
  assign progData = progData_reg;
  assign progBytes = progBytes_reg;
  assign busy = busy_reg;
  assign addrCount = addrCount_reg;

endmodule : eeprom_target

// *** shared/eeprom_pkg.sv ***
// Shared constants and state types of the serial memory target and its bus master
package eeprom_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Select byte layout
  localparam int BYTE_BITS = 8;
  // Type identifier value is arbitrary
  localparam logic [3:0] DEV_TYPE_ID = 4'h5;
  localparam logic [2:0] CHIP_FIELD = 3'h1;
  localparam logic RW_WRITE = 1'b0;
  localparam logic RW_READ = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Addressing and counts
  localparam int FULL_ADDR_W = 16;
  localparam int ARRAY_ADDR_W = 12;
  localparam int DATA_CNT_W = 6;
  localparam int PROG_CYCLES = 1000;
  localparam int QTR_CYCLES = 4;
  localparam int QTR_MIN = 4;
  localparam logic [3:0] BIT_LAST_DATA = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [2:0] LAST_BYTE_PROBE = 3'h0;
  localparam logic [2:0] LAST_BYTE_WRITE = 3'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Target byte sequencer states
  typedef enum logic [4:0] {
    LNK_SEL = 5'h01,
    LNK_ADDR_HI = 5'h02,
    LNK_ADDR_LO = 5'h04,
    LNK_DATA = 5'h08,
    LNK_PARK = 5'h10
  } lnk_e;

  // Master sequencer states
  typedef enum logic [3:0] {
    M_IDLE = 4'h1,
    M_START = 4'h2,
    M_BITS = 4'h4,
    M_STOP = 4'h8
  } mst_e;

endpackage : eeprom_pkg

// *** shared/i2c_link_if.sv ***
// Two-wire link between the bus master and the memory target
`timescale 1ns/1ns
interface i2c_link_if;
  // Serial clock, made by the master
  logic scl;
  // Open-drain data drivers
  logic hostSdaOut;
  logic hostSdaOe;
  logic devSdaOut;
  logic devSdaOe;
  // Resolved data line level with pull-up
  logic sdaLevel;

  // Wired line: low while any enabled driver pulls low
  assign sdaLevel = ~((hostSdaOe & ~hostSdaOut) | (devSdaOe & ~devSdaOut));

  modport device (
    input scl,
    input sdaLevel,
    output devSdaOut,
    output devSdaOe
  );

  modport host (
    output scl,
    input sdaLevel,
    output hostSdaOut,
    output hostSdaOe
  );
endinterface : i2c_link_if

// *** rtl/eeprom_host.sv ***
// Bus master end: byte write and select probe over the two-wire link
`timescale 1ns/1ns
module eeprom_host import eeprom_pkg::*; #(
  parameter int QTR = QTR_CYCLES,
  parameter logic [3:0] TYPE_ID = DEV_TYPE_ID
) (
  // System clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Serial link
  i2c_link_if.host link,
  // Command port
  input wire logic cmdValid,
  output logic cmdReady,
  input wire logic cmdProbe,
  input wire logic [FULL_ADDR_W-1:0] cmdAddr,
  input wire logic [7:0] cmdData,
  // Response port
  output logic rspValid,
  output logic [2:0] rspAckCount,
  output logic rspNack
);

  localparam int QW = $clog2(QTR + 1);

  // Start and Stop must stand long enough for the target to see them
  if (QTR < QTR_MIN) begin : gQtrCheck
    $error("QTR too small");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  mst_e state_reg, state_next;
  logic [QW-1:0] qCnt_reg, qCnt_next;
  logic [1:0] quarter_reg, quarter_next;
  logic [3:0] bitIdx_reg, bitIdx_next;
  logic [2:0] byteIdx_reg, byteIdx_next;
  logic [2:0] lastByte_reg, lastByte_next;
  logic [31:0] bytes_reg, bytes_next;
  logic sclOut_reg, sclOut_next;
  logic sdaLow_reg, sdaLow_next;
  logic [1:0] sdaSync_reg, sdaSync_next;
  logic [2:0] ackCnt_reg, ackCnt_next;
  logic nack_reg, nack_next;
  logic rspValid_reg, rspValid_next;
  logic tick;

  ////////////////////////////////////////////////////////////////////////////
  // Quarter-bit sequencer; the clock is divided down from clk
  always_comb begin
    sdaSync_next = {sdaSync_reg[0], link.sdaLevel};
    tick = (qCnt_reg == QW'(QTR - 1));
    qCnt_next = tick ? '0 : qCnt_reg + 1'b1;
    quarter_next = tick ? quarter_reg + 2'h1 : quarter_reg;
    state_next = state_reg;
    bitIdx_next = bitIdx_reg;
    byteIdx_next = byteIdx_reg;
    lastByte_next = lastByte_reg;
    bytes_next = bytes_reg;
    sclOut_next = sclOut_reg;
    sdaLow_next = sdaLow_reg;
    ackCnt_next = ackCnt_reg;
    nack_next = nack_reg;
    rspValid_next = 1'b0;
    unique case (state_reg)
      M_IDLE: begin
        qCnt_next = '0;
        quarter_next = 2'h0;
        if (cmdValid) begin
          bytes_next = {TYPE_ID, CHIP_FIELD, RW_WRITE, cmdAddr, cmdData}; // RQ9
          lastByte_next = cmdProbe ? LAST_BYTE_PROBE : LAST_BYTE_WRITE;
          byteIdx_next = 3'h0;
          bitIdx_next = 4'h0;
          ackCnt_next = 3'h0;
          nack_next = 1'b0;
          state_next = M_START; // RQ4
        end
      end
      M_START: begin
        if (tick) begin
          unique case (quarter_reg)
            2'h0: sdaLow_next = 1'b1; // RQ3
            2'h1: sdaLow_next = 1'b1;
            2'h2: sclOut_next = 1'b0;
            2'h3: state_next = M_BITS;
          endcase
        end
      end
      M_BITS: begin
        if (tick) begin
          unique case (quarter_reg)
            2'h0: sdaLow_next = (bitIdx_reg == BIT_ACK) ? 1'b0 : ~bytes_reg[31]; // RQ2
            2'h1: sclOut_next = 1'b1;
            2'h2: begin
              if (bitIdx_reg == BIT_ACK) begin
                if (!sdaSync_reg[1]) begin
                  ackCnt_next = ackCnt_reg + 3'h1; // RQ8
                end else begin
                  nack_next = 1'b1;
                end
              end
            end
            2'h3: begin
              sclOut_next = 1'b0;
              if (bitIdx_reg == BIT_ACK) begin
                bitIdx_next = 4'h0;
                byteIdx_next = byteIdx_reg + 3'h1;
                if (nack_reg || byteIdx_reg == lastByte_reg) begin
                  state_next = M_STOP;
                end
              end else begin
                bitIdx_next = bitIdx_reg + 4'h1;
                bytes_next = {bytes_reg[30:0], 1'b0}; // RQ14
              end
            end
          endcase
        end
      end
      M_STOP: begin
        if (tick) begin
          unique case (quarter_reg)
            2'h0: sdaLow_next = 1'b1;
            2'h1: sclOut_next = 1'b1;
            2'h2: sdaLow_next = 1'b0; // RQ6
            2'h3: begin
              state_next = M_IDLE;
              rspValid_next = 1'b1;
            end
          endcase
        end
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= M_IDLE;
      qCnt_reg <= '0;
      quarter_reg <= 2'h0;
      bitIdx_reg <= 4'h0;
      byteIdx_reg <= 3'h0;
      lastByte_reg <= 3'h0;
      bytes_reg <= 32'h0000_0000;
      sclOut_reg <= 1'b1;
      sdaLow_reg <= 1'b0;
      sdaSync_reg <= 2'h3;
      ackCnt_reg <= 3'h0;
      nack_reg <= 1'b0;
      rspValid_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      qCnt_reg <= qCnt_next;
      quarter_reg <= quarter_next;
      bitIdx_reg <= bitIdx_next;
      byteIdx_reg <= byteIdx_next;
      lastByte_reg <= lastByte_next;
      bytes_reg <= bytes_next;
      sclOut_reg <= sclOut_next;
      sdaLow_reg <= sdaLow_next;
      sdaSync_reg <= sdaSync_next;
      ackCnt_reg <= ackCnt_next;
      nack_reg <= nack_next;
      rspValid_reg <= rspValid_next;
    end
  end

  // Outputs
  assign link.scl = sclOut_reg;
  assign link.hostSdaOut = 1'b0;
  assign link.hostSdaOe = sdaLow_reg;
  assign cmdReady = (state_reg == M_IDLE);
  assign rspValid = rspValid_reg;
  assign rspAckCount = ackCnt_reg;
  assign rspNack = nack_reg;

endmodule : eeprom_host

// *** bench/eeprom_i2c_target_front_end_monitor.sv ***
// Link and program cycle checks beside the two-wire link
`timescale 1ns/1ns
module eeprom_i2c_target_front_end_monitor import eeprom_pkg::*; #(
  parameter int PROG_LEN = PROG_CYCLES,
  parameter int ADDR_W = ARRAY_ADDR_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Link signals
  input wire logic scl,
  input wire logic hostSdaOut,
  input wire logic hostSdaOe,
  input wire logic devSdaOut,
  input wire logic devSdaOe,
  input wire logic sdaLevel,
  // Program cycle side
  input wire logic progStart,
  input wire logic busy,
  input wire logic [ADDR_W-1:0] progAddr,
  input wire logic [DATA_CNT_W-1:0] progBytes,
  input wire logic [ADDR_W-1:0] addrCount
);
  int busyCnt_reg;
  int busyCnt_next;

  ////////////////////////////////////////////////////////////////////////////
  // Length of the current busy interval
  always_comb begin
    busyCnt_next = busy ? busyCnt_reg + 1 : 0;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busyCnt_reg <= 0;
    end else begin
      busyCnt_reg <= busyCnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  open_drain_a: assert property (devSdaOe |-> !devSdaOut)
    else $error("target drives data high");
  busy_quiet_a: assert property (busy |-> !devSdaOe)
    else $error("target pulls data while busy");
  busy_start_a: assert property ($rose(busy) |-> progStart)
    else $error("busy rose without program start");
  start_pulse_a: assert property (progStart |=> !progStart && busy)
    else $error("program start not a single pulse");
  busy_len_a: assert property ($fell(busy) |-> busyCnt_reg == PROG_LEN)
    else $error("busy length wrong");
  count_load_a: assert property ($fell(busy) |-> ##[0:1] addrCount == progAddr + progBytes)
    else $error("address counter not past last byte");
  ack_hold_a: assert property ($rose(scl) && devSdaOe |-> devSdaOe [*6])
    else $error("acknowledge dropped during clock high");
  ack_edge_a: assert property ($changed(devSdaOe) |-> !scl)
    else $error("target data changed while clock high");
  reset_quiet_a: assert property (@(posedge clk) disable iff (1'b0)
    !rstn |-> !devSdaOe && !busy && !progStart)
    else $error("target active in reset");
  data_setup_a: assert property ($rose(scl) |-> $stable(hostSdaOe))
    else $error("host data changed at clock rise");
  line_low_a: assert property (hostSdaOe || devSdaOe |-> !sdaLevel && !hostSdaOut)
    else $error("enabled driver does not pull the line low");

  // Main scenarios
  prog_c: cover property (progStart);
  done_c: cover property ($fell(busy));
  ack_c: cover property ($rose(devSdaOe));
endmodule : eeprom_i2c_target_front_end_monitor

// *** bench/eeprom_i2c_target_front_end_tb_top.sv ***
// Testbench: host and target joined over the link, plus a mismatching host pair
`timescale 1ns/1ns
module eeprom_i2c_target_front_end_tb_top import eeprom_pkg::*;;
  localparam int PLEN = 400;
  localparam logic [7:0] SEL = {DEV_TYPE_ID, CHIP_FIELD, RW_WRITE};
  logic clk;
  logic rstn;
  logic cmdValid, cmdValidB, cmdProbe;
  logic [15:0] cmdAddr;
  logic [7:0] cmdData;
  logic cmdReady, cmdReadyB, rspValid, rspValidB, rNack, rNackB;
  logic [2:0] rAck, rAckB;
  logic progStart, busy;
  logic [11:0] progAddr, addrCount;
  logic [7:0] progData;
  logic [DATA_CNT_W-1:0] progBytes;
  logic [36:0] frame;
  int failures = 0;
  int n_compared = 0;

  i2c_link_if link ();
  i2c_link_if linkB ();

  ////////////////////////////////////////////////////////////////////////////
  // Design ends and checker
  eeprom_target #(.PROG_LEN(PLEN)) u_eeprom_target (.clk(clk), .rstn(rstn), .link(link),
    .progStart(progStart), .progAddr(progAddr), .progData(progData), .progBytes(progBytes),
    .busy(busy), .addrCount(addrCount));
  eeprom_host u_eeprom_host (.clk(clk), .rstn(rstn), .link(link), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmdProbe(cmdProbe), .cmdAddr(cmdAddr), .cmdData(cmdData),
    .rspValid(rspValid), .rspAckCount(rAck), .rspNack(rNack));
  eeprom_target #(.PROG_LEN(PLEN)) u_eeprom_target_b (.clk(clk), .rstn(rstn), .link(linkB),
    .progStart(), .progAddr(), .progData(), .progBytes(), .busy(), .addrCount());
  // Host with a wrong type identifier
  eeprom_host #(.TYPE_ID(DEV_TYPE_ID ^ 4'h1)) u_eeprom_host_b (.clk(clk), .rstn(rstn),
    .link(linkB), .cmdValid(cmdValidB), .cmdReady(cmdReadyB), .cmdProbe(cmdProbe),
    .cmdAddr(cmdAddr), .cmdData(cmdData), .rspValid(rspValidB), .rspAckCount(rAckB),
    .rspNack(rNackB));
  eeprom_i2c_target_front_end_monitor #(.PROG_LEN(PLEN), .ADDR_W(12)) u_monitor (
    .clk(clk), .rstn(rstn), .scl(link.scl), .hostSdaOut(link.hostSdaOut),
    .hostSdaOe(link.hostSdaOe), .devSdaOut(link.devSdaOut), .devSdaOe(link.devSdaOe),
    .sdaLevel(link.sdaLevel), .progStart(progStart), .busy(busy), .progAddr(progAddr),
    .progBytes(progBytes), .addrCount(addrCount));

  ////////////////////////////////////////////////////////////////////////////
  // Clock and wire sampler: the last 37 levels seen at serial clock rises
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial frame = '0;
  always @(posedge link.scl) frame <= {frame[35:0], link.sdaLevel};

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task check(input string name, input logic [39:0] seen, input logic [39:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task end_of_test();
    $display("Compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  // One command, held until taken, then wait for its response
  task run_cmd(input logic useB, input logic probe, input logic [15:0] addr,
               input logic [7:0] data);
    int n;
    @(posedge clk);
    #2;
    cmdProbe = probe;
    cmdAddr = addr;
    cmdData = data;
    if (useB) cmdValidB = 1'b1;
    else cmdValid = 1'b1;
    // Ready depends on host state only, so it is settled here and holds to the next edge
    n = 0;
    while ((useB ? cmdReadyB : cmdReady) !== 1'b1 && n < 100) begin
      @(posedge clk);
      #2;
      n++;
    end
    check("command ready", (useB ? cmdReadyB : cmdReady), 1'b1);
    @(posedge clk);
    #2;
    cmdValid = 1'b0;
    cmdValidB = 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while ((useB ? rspValidB : rspValid) !== 1'b1 && n < 3000);
    if (n >= 3000) check("response", 1'b0, 1'b1);
  endtask : run_cmd

  task wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    check("busy done", busy, 1'b0);
    repeat (3) @(posedge clk);
  endtask : wait_idle

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    end_of_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    rstn = 1'b0;
    cmdValid = 1'b0;
    cmdValidB = 1'b0;
    cmdProbe = 1'b0;
    cmdAddr = 16'h0000;
    cmdData = 8'h00;
    repeat (16) @(posedge clk);
    #2 rstn = 1'b1;
    repeat (4) @(posedge clk);
    // Byte write, every byte acknowledged
    run_cmd(1'b0, 1'b0, 16'h0123, 8'ha5);
    check("write acks", rAck, 3'h4);
    check("write nack", rNack, 1'b0);
    check("write frame", frame,
      {SEL, 1'b0, 8'h01, 1'b0, 8'h23, 1'b0, 8'ha5, 1'b0, 1'b0});
    // Probe during the program cycle gets no acknowledge
    run_cmd(1'b0, 1'b1, 16'h0000, 8'h00);
    check("busy probe acks", rAck, 3'h0);
    check("busy probe nack", rNack, 1'b1);
    check("busy probe frame", frame[9:0], {SEL, 1'b1, 1'b0});
    check("busy held", busy, 1'b1);
    wait_idle();
    check("prog addr", progAddr, 12'h123);
    check("prog data", progData, 8'ha5);
    check("prog bytes", progBytes, 6'h01);
    check("addr count", addrCount, 12'h124);
    // Probe after the program cycle is acknowledged
    run_cmd(1'b0, 1'b1, 16'h0000, 8'h00);
    check("probe acks", rAck, 3'h1);
    check("probe nack", rNack, 1'b0);
    check("probe frame", frame[9:0], {SEL, 1'b0, 1'b0});
    check("probe no program", busy, 1'b0);
    // Wrong type identifier is refused
    run_cmd(1'b1, 1'b0, 16'h0456, 8'h5a);
    check("mismatch acks", rAckB, 3'h0);
    check("mismatch nack", rNackB, 1'b1);
    // Reset in the middle of a write
    @(posedge clk);
    #2;
    cmdProbe = 1'b0;
    cmdValid = 1'b1;
    @(posedge clk);
    #2 cmdValid = 1'b0;
    repeat (100) @(posedge clk);
    #2 rstn = 1'b0;
    repeat (16) @(posedge clk);
    check("reset release", link.devSdaOe, 1'b0);
    check("reset scl", link.scl, 1'b1);
    check("reset host oe", link.hostSdaOe, 1'b0);
    check("reset busy", busy, 1'b0);
    #2 rstn = 1'b1;
    repeat (4) @(posedge clk);
    // Write at the top of the array: counter wraps
    run_cmd(1'b0, 1'b0, 16'h0fff, 8'h3c);
    check("wrap acks", rAck, 3'h4);
    wait_idle();
    check("wrap count", addrCount, 12'h000);
    check("wrap data", progData, 8'h3c);
    end_of_test();
  end
endmodule : eeprom_i2c_target_front_end_tb_top
